//--- src/wcd_params.svh
/*
  Offsets, field positions, reset values and timing counts of the
  wake-up card detector. Assumes an 8-bit register port.
*/
`ifndef WCD_PARAMS_SVH
`define WCD_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define WCD_A_OPCTL    8'h02
`define WCD_A_WTC      8'h32
`define WCD_A_CH_BASE  8'h33
`define WCD_A_STS      8'h3b
`define WCD_A_MASK     8'h3c

// ****************************************
// fields and reset values
// ****************************************
`define WCD_OP_WAKE    2
`define WCD_WTC_LONG   3
`define WCD_WTC_AMP    6
`define WCD_WTC_PH     7
`define WCD_WTC_RST    8'h08
`define WCD_STS_TMR    0
`define WCD_STS_DEV0   1

// ****************************************
// timing
// ****************************************
`define WCD_RC_HZ      32000
`define WCD_UNIT_MS    10
`define WCD_RC_TICKS   ((`WCD_RC_HZ * `WCD_UNIT_MS) / 1000)
`define WCD_LONG_MUL   10
`define WCD_FIELD_NS   20000
`define WCD_CLK_NS     5
`define WCD_FIELD_CYC  (`WCD_FIELD_NS / `WCD_CLK_NS)

`endif

//--- src/wcd_pkg.sv
/*
  Types of the wake-up card detector.
  Assumes wcd_params.svh supplies the numbers.
*/
package wcd_pkg;

  typedef enum logic [2:0] {
    WCD_IDLE  = 3'b001,
    WCD_SENSE = 3'b010,
    WCD_EVAL  = 3'b100
  } wcd_state_e;

  // per-measurement configuration register
  typedef struct packed {
    logic [3:0] thr;
    logic       incl;
    logic [1:0] wsel;
    logic       auto_ref;
  } wcd_cfg_s;

  // decoded channel register access
  typedef struct packed {
    logic       hit;
    logic       ch;
    logic [1:0] sub;
  } wcd_rsel_s;

endpackage : wcd_pkg

//--- src/wcd_detector.sv
/*
  Wake-up card-presence detector: wake timer on the RC oscillator,
  phase and amplitude measurement scheduling, reference keeping,
  threshold compare, sticky status and interrupt.
  Assumes the analog front end answers meas_start on core_clk with
  meas_done and meas_value; rc_osc_clk is an asynchronous pin.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wcd_params.svh"

// Notes on behaviour
// - wake mode: only wake bit set
// - phase and amplitude measurements selectable
// - wake timer counts RC oscillator ticks
// - measure each period, interrupt on deviation
// - periods 10 to 800 ms, reset 100
// - timer control selects measurement types
// - field on only briefly per measurement
// - contiguous wake register range
// - four registers per measurement type
// - interrupt when |diff| exceeds threshold
// - reference auto-averaged or host written
// - first expiry stores measurement as reference
// - init redone on each mode entry
// - no deviation interrupt at first expiry; code suppresses it only with auto reference
// - ref minus (ref minus value)/weight
// - average kept with ten bits
// - config bit includes triggering measurement
module wcd_detector #(
  parameter int RC_TICKS  = `WCD_RC_TICKS,
  parameter int FIELD_CYC = `WCD_FIELD_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rc_osc_clk,
  output logic            field_en,
  output logic            meas_start,
  output logic            meas_phase,
  input  wire logic       meas_done,
  input  wire logic [7:0] meas_value,
  output logic            wake_mode,
  output logic            irq
);

  // ****************************************
  // decode
  // ****************************************
  function automatic wcd_pkg::wcd_rsel_s ch_dec(input logic [7:0] a);
    logic [7:0] o;
    o = a - `WCD_A_CH_BASE;
    ch_dec.hit = (a >= `WCD_A_CH_BASE) && (o < 8'h08);
    ch_dec.ch  = o[2];
    ch_dec.sub = o[1:0];
  endfunction : ch_dec

  wcd_pkg::wcd_rsel_s   wsel_c;
  wcd_pkg::wcd_rsel_s   rsel_c;
  logic           [7:0] op_q;
  logic           [7:0] wtc_q;
  logic           [2:0] sts_q;
  logic           [2:0] mask_q;
  wcd_pkg::wcd_cfg_s    cfg_q  [2];
  logic           [7:0] href_q [2];
  logic           [9:0] avg_q  [2];
  logic           [7:0] res_q  [2];
  logic                 init_q [2];
  logic           [1:0] dev_c;
  logic           [1:0] exceed_c;
  logic                 mode_q;
  logic                 mode_rise;
  logic                 expire;
  wcd_pkg::wcd_state_e  st_q;
  logic                 cur_q;
  logic           [1:0] pend_q;
  logic           [7:0] mv_q;
  logic          [11:0] fcnt_q;

  assign wsel_c = ch_dec(reg_addr);
  assign rsel_c = ch_dec(reg_addr);

  // ****************************************
  // control registers
  // ****************************************
  // host keeps these stable while the mode runs, so no shadowing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_q   <= 8'h00;
      wtc_q  <= `WCD_WTC_RST;
      mask_q <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == `WCD_A_OPCTL) begin
        op_q <= reg_wdata;
      end else if (reg_addr == `WCD_A_WTC) begin
        wtc_q <= reg_wdata;
      end else if (reg_addr == `WCD_A_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_hreg
      always_ff @(posedge core_clk) begin
        if (rst) begin
          cfg_q[g]  <= '0;
          href_q[g] <= 8'h00;
        end else if (reg_wr && wsel_c.hit && wsel_c.ch == 1'(g)) begin
          if (wsel_c.sub == 2'd0) begin
            cfg_q[g] <= reg_wdata;
          end else if (wsel_c.sub == 2'd1) begin
            href_q[g] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `WCD_A_OPCTL) begin
      reg_rdata <= op_q;
    end else if (reg_addr == `WCD_A_WTC) begin
      reg_rdata <= wtc_q;
    end else if (rsel_c.hit) begin
      case (rsel_c.sub)
        2'd0:    reg_rdata <= cfg_q[rsel_c.ch];
        2'd1:    reg_rdata <= href_q[rsel_c.ch];
        2'd2:    reg_rdata <= avg_q[rsel_c.ch][9:2];
        default: reg_rdata <= res_q[rsel_c.ch];
      endcase
    end else if (reg_addr == `WCD_A_STS) begin
      reg_rdata <= {5'h00, sts_q};
    end else if (reg_addr == `WCD_A_MASK) begin
      reg_rdata <= {5'h00, mask_q};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // mode entry
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= (op_q == (8'h01 << `WCD_OP_WAKE));
    end
  end

  assign mode_rise = (op_q == (8'h01 << `WCD_OP_WAKE)) && !mode_q;
  assign wake_mode = mode_q;

  // ****************************************
  // wake timer on the rc oscillator
  // ****************************************
  logic        rc_s1_q;
  logic        rc_s2_q;
  logic        rc_s3_q;
  logic        rc_tick;
  logic [8:0]  tick_q;
  logic [6:0]  unit_q;
  logic [6:0]  unit_lim;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_osc_clk;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  assign rc_tick  = rc_s2_q && !rc_s3_q;
  // short range 10..80 ms, long range 100..800 ms
  assign unit_lim = wtc_q[`WCD_WTC_LONG]
                  ? 7'(({4'h0, wtc_q[2:0]} + 7'd1) * `WCD_LONG_MUL)
                  : 7'({4'h0, wtc_q[2:0]} + 7'd1);

  always_ff @(posedge core_clk) begin
    if (rst || !mode_q) begin
      tick_q <= 9'h000;
      unit_q <= 7'h00;
    end else if (rc_tick) begin
      if (tick_q == 9'(RC_TICKS - 1)) begin
        tick_q <= 9'h000;
        unit_q <= expire ? 7'h00 : unit_q + 7'd1;
      end else begin
        tick_q <= tick_q + 9'd1;
      end
    end
  end

  assign expire = mode_q && rc_tick && (tick_q == 9'(RC_TICKS - 1))
                && (unit_q == unit_lim - 7'd1);

  // ****************************************
  // measurement sequencer
  // ****************************************
  // a measurement still running when the mode drops is finished
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q   <= wcd_pkg::WCD_IDLE;
      cur_q  <= 1'b0;
      pend_q <= 2'b00;
      mv_q   <= 8'h00;
      fcnt_q <= 12'h000;
    end else begin
      case (st_q)
        wcd_pkg::WCD_IDLE: begin
          if (expire && (wtc_q[`WCD_WTC_AMP] || wtc_q[`WCD_WTC_PH])) begin
            pend_q <= {wtc_q[`WCD_WTC_PH], wtc_q[`WCD_WTC_AMP]};
            cur_q  <= !wtc_q[`WCD_WTC_AMP];
            fcnt_q <= 12'h000;
            st_q   <= wcd_pkg::WCD_SENSE;
          end
        end
        wcd_pkg::WCD_SENSE: begin
          fcnt_q <= fcnt_q + 12'd1;
          if (meas_done) begin
            mv_q <= meas_value;
            st_q <= wcd_pkg::WCD_EVAL;
          end else if (fcnt_q == 12'(FIELD_CYC - 1)) begin
            pend_q[cur_q] <= 1'b0;
            cur_q         <= 1'b1;
            fcnt_q        <= 12'h000;
            st_q          <= (!cur_q && pend_q[1]) ? wcd_pkg::WCD_SENSE
                                                   : wcd_pkg::WCD_IDLE;
          end
        end
        wcd_pkg::WCD_EVAL: begin
          pend_q[cur_q] <= 1'b0;
          cur_q         <= 1'b1;
          fcnt_q        <= 12'h000;
          st_q          <= (!cur_q && pend_q[1]) ? wcd_pkg::WCD_SENSE
                                                 : wcd_pkg::WCD_IDLE;
        end
        default: st_q <= wcd_pkg::WCD_IDLE;
      endcase
    end
  end

  assign field_en   = (st_q == wcd_pkg::WCD_SENSE);
  assign meas_start = field_en && (fcnt_q == 12'h000);
  assign meas_phase = cur_q;

  // ****************************************
  // per-channel reference and compare
  // ****************************************
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic               ev;
      logic        [7:0]  ref_v;
      logic signed [8:0]  dlt;
      logic        [8:0]  mag;
      logic signed [10:0] ad;
      logic signed [10:0] adj;
      logic signed [10:0] q;
      logic        [10:0] nv;

      assign ev    = (st_q == wcd_pkg::WCD_EVAL) && (cur_q == 1'(g));
      assign ref_v = cfg_q[g].auto_ref ? avg_q[g][9:2] : href_q[g];
      assign dlt   = $signed({1'b0, mv_q}) - $signed({1'b0, ref_v});
      assign mag   = dlt[8] ? 9'(-dlt) : dlt;
      assign exceed_c[g] = mag > {5'h00, cfg_q[g].thr};
      assign dev_c[g]    = ev && exceed_c[g] && !init_q[g];
      // old minus new sample, both on ten bits
      assign ad  = $signed({1'b0, avg_q[g]}) - $signed({1'b0, mv_q, 2'b00});
      assign adj = ad[10] ? 11'(ad + ((11'sd1 <<< cfg_q[g].wsel) - 11'sd1)) : ad;
      assign q   = adj >>> cfg_q[g].wsel;
      assign nv  = 11'({1'b0, avg_q[g]} - q);

      always_ff @(posedge core_clk) begin
        if (rst) begin
          avg_q[g]  <= 10'h000;
          res_q[g]  <= 8'h00;
          init_q[g] <= 1'b0;
        end else if (mode_rise) begin
          init_q[g] <= cfg_q[g].auto_ref;
        end else if (ev) begin
          res_q[g] <= mv_q;
          if (init_q[g]) begin
            avg_q[g]  <= {mv_q, 2'b00};
            init_q[g] <= 1'b0;
          end else if (cfg_q[g].auto_ref
                       && !(exceed_c[g] && !cfg_q[g].incl)) begin
            avg_q[g] <= nv[9:0];
          end
        end
      end

      property p_init_store;
        @(posedge core_clk) disable iff (rst)
        (ev && init_q[g] && !mode_rise) |=> (avg_q[g] == {$past(mv_q), 2'b00});
      endproperty
      a_init_store: assert property (p_init_store)
        else $error("first sample not stored as reference");

      property p_entry_init;
        @(posedge core_clk) disable iff (rst)
        (mode_rise && cfg_q[g].auto_ref) |=> init_q[g];
      endproperty
      a_entry_init: assert property (p_entry_init)
        else $error("reference init not armed on entry");

      property p_excluded_hold;
        @(posedge core_clk) disable iff (rst)
        (ev && !init_q[g] && !mode_rise && exceed_c[g] && !cfg_q[g].incl)
          |=> $stable(avg_q[g]);
      endproperty
      a_excluded_hold: assert property (p_excluded_hold)
        else $error("excluded sample changed the average");

      property p_dev_cause;
        @(posedge core_clk) disable iff (rst)
        $rose(sts_q[`WCD_STS_DEV0 + g]) |->
          $past(ev && exceed_c[g] && !init_q[g]);
      endproperty
      a_dev_cause: assert property (p_dev_cause)
        else $error("deviation flag without cause");
    end
  endgenerate

  // ****************************************
  // status and interrupt
  // ****************************************
  logic [2:0] set_c;
  logic [2:0] clr_c;

  // timer flag only when the period runs with no measurement enabled
  assign set_c = {dev_c, expire && !wtc_q[`WCD_WTC_AMP] && !wtc_q[`WCD_WTC_PH]};
  assign clr_c = (reg_wr && reg_addr == `WCD_A_STS) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sts_q <= 3'h0;
    end else begin
      sts_q <= (sts_q & ~clr_c) | set_c;
    end
  end

  assign irq = |(sts_q & mask_q);

  // ****************************************
  // checks
  // ****************************************
  property p_mode_sel;
    @(posedge core_clk) disable iff (rst)
    mode_q == $past(op_q == (8'h01 << `WCD_OP_WAKE));
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("wake mode not tied to sole wake bit");

  // cycles the field has been on in the current measurement
  logic [12:0] fon_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fon_q <= 13'h0000;
    end else if (meas_start) begin
      fon_q <= 13'h0001;
    end else if (field_en) begin
      fon_q <= fon_q + 13'd1;
    end else begin
      fon_q <= 13'h0000;
    end
  end

  property p_field_short;
    @(posedge core_clk) disable iff (rst)
    (field_en && !meas_start) |-> (fon_q < 13'(FIELD_CYC));
  endproperty
  a_field_short: assert property (p_field_short)
    else $error("field stays on too long");

  property p_start_needs_expiry;
    @(posedge core_clk) disable iff (rst)
    ($rose(field_en) && $past(st_q == wcd_pkg::WCD_IDLE)) |-> $past(expire);
  endproperty
  a_start_needs_expiry: assert property (p_start_needs_expiry)
    else $error("measurement without timer expiry");

  property p_expire_in_mode;
    @(posedge core_clk) disable iff (rst)
    expire |-> mode_q && rc_tick;
  endproperty
  a_expire_in_mode: assert property (p_expire_in_mode)
    else $error("timer expiry outside rc tick or mode");

  property p_irq_level;
    @(posedge core_clk) disable iff (rst)
    (set_c != 3'h0) |=> ##1 (irq == |(sts_q & mask_q)) && ((sts_q & $past(set_c, 2)) != 3'h0);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("event lost or interrupt mismatch");

  property p_sel_follows;
    @(posedge core_clk) disable iff (rst)
    meas_start |-> (meas_phase ? wtc_q[`WCD_WTC_PH] : wtc_q[`WCD_WTC_AMP]);
  endproperty
  a_sel_follows: assert property (p_sel_follows)
    else $error("measurement type not enabled");

endmodule : wcd_detector

`default_nettype wire

//--- dv/wcd_fe_model.sv
/*
  Behavioural analog front end: answers meas_start with meas_done.
  Assumes the detector holds field_en while it waits for the result.
*/
`timescale 1ns/100ps
`default_nettype none
module wcd_fe_model #(
  parameter int DLY = 3
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       meas_start,
  input  wire logic       field_en,
  input  wire logic [7:0] value,
  output logic            meas_done,
  output logic      [7:0] meas_value
);
  int   cnt_q;
  logic busy_q;
  // ****************************************
  // result after a short field-on time
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q     <= 1'b0;
      cnt_q      <= 0;
      meas_done  <= 1'b0;
      meas_value <= 8'h00;
    end else begin
      meas_done  <= 1'b0;
      // idle value bus keeps changing so a stale sample cannot match
      meas_value <= ~meas_value;
      if (meas_start) begin
        busy_q <= 1'b1;
        cnt_q  <= DLY;
      end else if (busy_q && field_en) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          busy_q     <= 1'b0;
          meas_done  <= 1'b1;
          meas_value <= value;
        end
      end
    end
  end
endmodule : wcd_fe_model
`default_nettype wire

//--- dv/test_wcd_detector.sv
/*
  Self-checking bench of the wake-up detector: register port host,
  front-end model, RC oscillator pin.
  Assumes shortened RC_TICKS and FIELD_CYC parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wcd_params.svh"
module test_wcd_detector;
  localparam int TICKS = 4;
  localparam int FIELD = 20;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr   = 1'b0;
  logic       reg_rd   = 1'b0;
  logic [7:0] reg_rdata;
  logic       rc_osc_clk = 1'b0;
  logic       field_en;
  logic       meas_start;
  logic       meas_phase;
  logic       meas_done;
  logic [7:0] meas_value;
  logic       wake_mode;
  logic       irq;
  logic [7:0] fe_val = 8'h00;
  logic [7:0] d;
  int         n_errors = 0;
  int         total_checks = 0;
  time        t_st;
  time        t0;

  always #2.5 core_clk = ~core_clk;
  // rc pin unrelated to core clock, 10 ms unit = TICKS of it
  always #50 rc_osc_clk = ~rc_osc_clk;

  wcd_detector #(.RC_TICKS(TICKS), .FIELD_CYC(FIELD)) dut_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_osc_clk(rc_osc_clk),
    .field_en(field_en), .meas_start(meas_start), .meas_phase(meas_phase),
    .meas_done(meas_done), .meas_value(meas_value), .wake_mode(wake_mode), .irq(irq));
  wcd_fe_model fe_u (
    .core_clk(core_clk), .rst(rst), .meas_start(meas_start), .field_en(field_en),
    .value(fe_val), .meas_done(meas_done), .meas_value(meas_value));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic mode(input logic [7:0] v);
    wr(`WCD_A_OPCTL, v);
    @(posedge core_clk);
    #1;
  endtask : mode
  task automatic meas(input logic [7:0] v, input logic ph);
    int n;
    int f;
    fe_val = v;
    n = 0;
    while (meas_start !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    t_st = $time;
    chk(8'(meas_phase), 8'(ph));
    f = 0;
    while (field_en === 1'b1 && f < 100) begin
      @(posedge core_clk);
      #1 f++;
    end
    chk(8'(f <= FIELD && n < 2000), 8'h01);
    // one edge only: a phase measurement starts right after this one
    @(posedge core_clk);
    #1;
  endtask : meas

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(`WCD_A_WTC, d);
    chk(d, `WCD_WTC_RST);
    rd(8'h20, d);
    chk(d, 8'h00);
    chk(8'({wake_mode, irq}), 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_timer;
    int n;
    // configuration complete before entry
    wr(`WCD_A_WTC, 8'h00);
    wr(`WCD_A_MASK, 8'h01);
    mode(8'h05);
    chk(8'(wake_mode), 8'h00);
    mode(8'h04);
    chk(8'(wake_mode), 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(8'(n < 300), 8'h01);
    mode(8'h00);
    rd(`WCD_A_STS, d);
    chk(d, 8'h01);
    wr(`WCD_A_STS, 8'h01);
    rd(`WCD_A_STS, d);
    chk({d[7:1], irq}, 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_host;
    wr(`WCD_A_CH_BASE, 8'h20);
    wr(8'h34, 8'h50);
    wr(`WCD_A_WTC, 8'h41);
    wr(`WCD_A_MASK, 8'h02);
    mode(8'h04);
    meas(8'h52, 1'b0);
    t0 = t_st;
    rd(`WCD_A_STS, d);
    chk(d, 8'h00);
    rd(8'h36, d);
    chk(d, 8'h52);
    meas(8'h53, 1'b0);
    // sel 1 gives two units of TICKS rc periods, 20 core cycles each
    chk(8'((t_st - t0) / 5 >= 135 && (t_st - t0) / 5 <= 185), 8'h01);
    chk(8'(irq), 8'h01);
    wr(`WCD_A_MASK, 8'h00);
    #1;
    chk(8'(irq), 8'h00);
    mode(8'h00);
    wr(`WCD_A_STS, 8'h07);
    $display("test host reference done");
  endtask : t_host
  task automatic t_auto;
    // threshold f, include bit clear, weight 2, auto reference
    wr(`WCD_A_CH_BASE, 8'hf3);
    wr(`WCD_A_WTC, 8'h40);
    wr(`WCD_A_MASK, 8'h02);
    mode(8'h04);
    meas(8'h40, 1'b0);
    rd(8'h35, d);
    chk(d, 8'h40);
    meas(8'h48, 1'b0);
    rd(8'h35, d);
    chk(d, 8'h44);
    mode(8'h00);
    mode(8'h04);
    meas(8'h60, 1'b0);
    rd(8'h35, d);
    chk(d, 8'h60);
    chk(8'(irq), 8'h00);
    meas(8'h80, 1'b0);
    chk(8'(irq), 8'h01);
    rd(8'h35, d);
    chk(d, 8'h60);
    mode(8'h00);
    wr(`WCD_A_STS, 8'h07);
    $display("test auto average done");
  endtask : t_auto
  task automatic t_phase;
    wr(8'h37, 8'hf0);
    wr(8'h38, 8'h10);
    wr(`WCD_A_WTC, 8'hc0);
    mode(8'h04);
    meas(8'h33, 1'b0);
    meas(8'h21, 1'b1);
    rd(8'h3a, d);
    chk(d, 8'h21);
    mode(8'h00);
    $display("test phase done");
  endtask : t_phase

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_timer();
    t_host();
    t_auto();
    t_phase();
    summarize();
  end
endmodule : test_wcd_detector
`default_nettype wire
